/* snw_node_cfg.sv */
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module snw_node_cfg #(
  parameter int TICK_CYCLES = snw_pkg::TICK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [7:0] cfg_dip,
  input wire logic [3:0] id_tens,
  input wire logic [3:0] id_units,
  input wire logic query_valid,
  input wire logic [7:0] query_unit,
  input wire logic out_write,
  input wire logic conn_req,
  input wire logic host_close,
  input wire logic [2:0] host_close_slot,
  input wire logic pkt_valid,
  input wire logic pkt_query,
  input wire logic [2:0] pkt_slot,
  input wire logic resp_done,
  input wire logic [2:0] resp_slot,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output snw_pkg::snw_frame_t frame,
  output logic [6:0] unit_id,
  output logic unit_id_ok,
  output logic safe_state,
  output logic conn_grant,
  output logic conn_refused,
  output logic [2:0] conn_slot,
  output logic [7:0] sess_open,
  output logic [7:0] sess_close,
  output logic [7:0] qry_timeout,
  output logic irq
);
  typedef struct packed {
    logic [7:0] dip_s1;
    logic [7:0] dip_s2;
    logic [7:0] id_s1;
    logic [7:0] id_s2;
    snw_pkg::snw_frame_t frame;
    logic [6:0] unit_id;
    logic unit_id_ok;
    logic wd_en;
    snw_pkg::snw_wd_t wd;
    logic [15:0] wd_cnt;
    logic safe;
    logic [15:0] wd_tmo;
    logic [15:0] idle_lim;
    logic [15:0] qtmo;
    logic [7:0] open;
    logic [7:0] qpend;
    logic [7:0][15:0] idle_cnt;
    logic [7:0][15:0] qcnt;
    logic conn_grant;
    logic conn_refused;
    logic [2:0] conn_slot;
    logic [7:0] sess_close;
    logic [7:0] qry_timeout;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    logic irq;
    logic [31:0] rdata;
  } snw_main_t;

  logic [1:0] rst_pipe;
  logic rst_n;
  logic tick_100ms;
  logic tick_sec;
  logic hit;
  snw_main_t st_reg;
  snw_main_t st_next;

  // reset release is synchronised so all flops leave reset on the same edge
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  snw_tick_gen #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .tick_100ms(tick_100ms),
    .tick_sec(tick_sec)
  );

  function automatic logic sel(input logic v, input logic [2:0] s, input int i);
    return v && (s == 3'(i));
  endfunction

  // query counts only if meant for this node or broadcast; a bad id answers nothing
  assign hit = query_valid && st_reg.unit_id_ok &&
    (query_unit == {1'b0, st_reg.unit_id} || query_unit == snw_pkg::ID_BCAST); // [RULE8]

  always_comb begin
    logic [3:0] ev;
    logic [3:0] w1c;
    ev = '0;
    w1c = '0;
    st_next = st_reg;
    // switch pins pass two flops before anything decodes them
    st_next.dip_s1 = cfg_dip;
    st_next.dip_s2 = st_reg.dip_s1;
    st_next.id_s1 = {id_tens, id_units};
    st_next.id_s2 = st_reg.id_s1;
    // all-off switches decode to 1200 N81 RTU, watchdog off
    st_next.frame = snw_pkg::decode_frame(st_reg.dip_s2); // [RULE1] [RULE2] [RULE3] [RULE4] [RULE5]
    st_next.wd_en = st_reg.dip_s2[snw_pkg::DIP_WD]; // [RULE1] [RULE9]
    st_next.unit_id = snw_pkg::bcd_id(st_reg.id_s2[7:4], st_reg.id_s2[3:0]); // [RULE7]
    st_next.unit_id_ok = (st_reg.id_s2[7:4] <= snw_pkg::BCD_MAX) &&
      (st_reg.id_s2[3:0] <= snw_pkg::BCD_MAX) && (st_reg.id_s2 != snw_pkg::ID_BCAST); // [RULE6]
    st_next.conn_grant = 1'b0;
    st_next.conn_refused = 1'b0;
    st_next.sess_close = '0;
    st_next.qry_timeout = '0;

    // communication watchdog; a zero timeout never trips
    unique case (st_reg.wd)
      snw_pkg::WD_OFF: begin
        if (st_reg.wd_en) begin
          st_next.wd = snw_pkg::WD_RUN;
          st_next.wd_cnt = '0;
        end
      end
      snw_pkg::WD_RUN: begin
        if (!st_reg.wd_en) begin
          st_next.wd = snw_pkg::WD_OFF;
        end else if (hit) begin
          st_next.wd_cnt = '0; // [RULE17]
        end else if (tick_100ms) begin
          if (st_reg.wd_tmo != '0 && st_reg.wd_cnt == st_reg.wd_tmo - 16'h1) begin
            st_next.wd = snw_pkg::WD_SAFE; // [RULE10] [RULE11]
            ev[snw_pkg::IRQ_WD] = 1'b1;
          end else begin
            st_next.wd_cnt = st_reg.wd_cnt + 16'h1;
          end
        end
      end
      snw_pkg::WD_SAFE: begin
        // a query alone is not enough; only fresh output values leave safe
        if (out_write) begin
          st_next.wd = st_reg.wd_en ? snw_pkg::WD_RUN : snw_pkg::WD_OFF; // [RULE17]
          st_next.wd_cnt = '0;
        end
      end
      default: st_next.wd = snw_pkg::WD_OFF;
    endcase
    st_next.safe = (st_next.wd == snw_pkg::WD_SAFE); // [RULE10]

    // per-session idle and query timers, both in whole seconds
    for (int i = 0; i < snw_pkg::SLOTS; i++) begin
      if (sel(host_close, host_close_slot, i)) begin
        st_next.open[i] = 1'b0;
        st_next.qpend[i] = 1'b0;
      end else if (st_reg.open[i]) begin
        if (sel(pkt_valid, pkt_slot, i)) begin
          st_next.idle_cnt[i] = '0;
          if (pkt_query) begin
            st_next.qpend[i] = 1'b1;
            st_next.qcnt[i] = '0;
          end
        end else if (tick_sec) begin
          if (st_reg.idle_lim != '0 && st_reg.idle_cnt[i] == st_reg.idle_lim - 16'h1) begin
            st_next.open[i] = 1'b0; // [RULE12] [RULE13]
            st_next.qpend[i] = 1'b0;
            st_next.sess_close[i] = 1'b1;
            ev[snw_pkg::IRQ_IDLE] = 1'b1;
          end else begin
            st_next.idle_cnt[i] = st_reg.idle_cnt[i] + 16'h1;
          end
          if (st_reg.qpend[i] && st_next.open[i]) begin
            if (st_reg.qtmo != '0 && st_reg.qcnt[i] == st_reg.qtmo - 16'h1) begin
              st_next.qpend[i] = 1'b0; // [RULE15]
              st_next.qry_timeout[i] = 1'b1;
              ev[snw_pkg::IRQ_QTMO] = 1'b1;
            end else begin
              st_next.qcnt[i] = st_reg.qcnt[i] + 16'h1;
            end
          end
        end
        if (sel(resp_done, resp_slot, i)) begin
          st_next.qpend[i] = 1'b0;
        end
      end
    end

    // new session takes the lowest free slot; a slot freed this cycle is reused next cycle
    if (conn_req) begin
      if (&st_reg.open) begin
        st_next.conn_refused = 1'b1; // [RULE14]
        ev[snw_pkg::IRQ_REFUSE] = 1'b1;
      end else begin
        st_next.conn_grant = 1'b1; // [RULE14]
        st_next.conn_slot = snw_pkg::first_free(st_reg.open);
        st_next.open[st_next.conn_slot] = 1'b1;
        st_next.qpend[st_next.conn_slot] = 1'b0;
        st_next.idle_cnt[st_next.conn_slot] = '0;
      end
    end

    // register writes
    if (reg_wr) begin
      unique case (reg_addr)
        snw_pkg::REG_WD_TMO: st_next.wd_tmo = reg_wdata[15:0]; // [RULE11]
        snw_pkg::REG_IDLE: st_next.idle_lim = reg_wdata[15:0];
        snw_pkg::REG_QTMO: st_next.qtmo = reg_wdata[15:0];
        snw_pkg::REG_IRQ_STAT: w1c = reg_wdata[3:0];
        snw_pkg::REG_IRQ_MASK: st_next.irq_mask = reg_wdata[3:0];
        default: st_next.irq_mask = st_reg.irq_mask;
      endcase
    end
    // a new event beats a clear written in the same cycle
    st_next.irq_stat = (st_reg.irq_stat & ~w1c) | ev;
    st_next.irq = |(st_next.irq_stat & st_next.irq_mask);

    // read data valid for exactly the cycle after the strobe; unmapped reads zero
    st_next.rdata = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        snw_pkg::REG_STATUS: st_next.rdata = 32'(snw_pkg::snw_status_t'({
          st_reg.wd, st_reg.safe, st_reg.wd_en, st_reg.frame.ascii, st_reg.frame.two_stop,
          st_reg.frame.seven_bits, st_reg.frame.parity, st_reg.frame.baud_code,
          st_reg.unit_id_ok, st_reg.unit_id}));
        snw_pkg::REG_WD_TMO: st_next.rdata = 32'(st_reg.wd_tmo);
        snw_pkg::REG_IDLE: st_next.rdata = 32'(st_reg.idle_lim);
        snw_pkg::REG_QTMO: st_next.rdata = 32'(st_reg.qtmo);
        snw_pkg::REG_IRQ_STAT: st_next.rdata = 32'(st_reg.irq_stat);
        snw_pkg::REG_IRQ_MASK: st_next.rdata = 32'(st_reg.irq_mask);
        snw_pkg::REG_SESS: st_next.rdata = 32'(snw_pkg::snw_sess_t'({
          4'($countones(st_reg.open)), st_reg.qpend, st_reg.open}));
        default: st_next.rdata = '0;
      endcase
    end
  end

  // single state register; watchdog starts disabled with the default timeout
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '{wd: snw_pkg::WD_OFF, wd_tmo: snw_pkg::WD_TMO_RST, // [RULE9] [RULE16]
        idle_lim: snw_pkg::IDLE_RST, qtmo: snw_pkg::QTMO_RST, default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state register
  assign reg_rdata = st_reg.rdata;
  assign frame = st_reg.frame;
  assign unit_id = st_reg.unit_id;
  assign unit_id_ok = st_reg.unit_id_ok;
  assign safe_state = st_reg.safe;
  assign conn_grant = st_reg.conn_grant;
  assign conn_refused = st_reg.conn_refused;
  assign conn_slot = st_reg.conn_slot;
  assign sess_open = st_reg.open;
  assign sess_close = st_reg.sess_close;
  assign qry_timeout = st_reg.qry_timeout;
  assign irq = st_reg.irq;

  // checks on the design's own behaviour
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_seven_bit_rtu: assert property (st_reg.frame.seven_bits |-> !st_reg.frame.ascii) // [RULE4]
    else $error("ascii selected with seven data bits");
  // the first edge after reset still shows the reset frame, so that edge is skipped
  a_baud_map: assert property ($past(rst_n) |-> // [RULE2]
    st_reg.frame.bit_div == snw_pkg::baud_div($past(st_reg.dip_s2[2:0])))
    else $error("baud divisor does not match switches");
  a_frame_map: assert property ($past(rst_n) |-> // [RULE3]
    st_reg.frame == snw_pkg::decode_frame($past(st_reg.dip_s2)))
    else $error("framing does not match switches");
  a_unit_id_range: assert property (st_reg.unit_id_ok |-> // [RULE6]
    (st_reg.unit_id >= 7'h01 && st_reg.unit_id <= 7'h63)) else $error("unit id out of range");
  a_unit_id_digits: assert property (st_reg.unit_id == snw_pkg::bcd_id( // [RULE7]
    $past(st_reg.id_s2[7:4]), $past(st_reg.id_s2[3:0]))) else $error("unit id digits wrong");
  a_wd_disabled: assert property (!st_reg.wd_en && st_reg.wd != snw_pkg::WD_SAFE |=> // [RULE9]
    st_reg.wd == snw_pkg::WD_OFF) else $error("watchdog runs while disabled");
  a_wd_trip: assert property (st_reg.wd == snw_pkg::WD_RUN && st_reg.wd_en && !hit && // [RULE10]
    tick_100ms && st_reg.wd_tmo != '0 && st_reg.wd_cnt == st_reg.wd_tmo - 16'h1 |=>
    safe_state && st_reg.irq_stat[snw_pkg::IRQ_WD]) else $error("watchdog failed to trip");
  a_safe_hold: assert property (safe_state && !out_write |=> safe_state) // [RULE17]
    else $error("safe state left without output write");
  a_query_restart: assert property (st_reg.wd == snw_pkg::WD_RUN && st_reg.wd_en && hit |=> // [RULE17]
    st_reg.wd_cnt == '0) else $error("query did not restart watchdog");
  a_idle_close: assert property (|sess_close |-> $past(tick_sec) && // [RULE12]
    (sess_close & sess_open) == '0) else $error("idle close outside second tick");
  a_idle_zero: assert property ($past(st_reg.idle_lim) == '0 |-> sess_close == '0) // [RULE13]
    else $error("session closed with idle interval zero");
  a_refuse_full: assert property (conn_refused |-> $past(&st_reg.open) && !conn_grant) // [RULE14]
    else $error("connection refused with a free slot");
  a_qtmo_tick: assert property (|qry_timeout |-> $past(tick_sec) && // [RULE15]
    $past(st_reg.qtmo) != '0) else $error("query timeout without tick");
  a_irq_level: assert property (irq == |(st_reg.irq_stat & st_reg.irq_mask))
    else $error("interrupt output disagrees with status and mask");

  c_wd_trip: cover property (st_reg.wd == snw_pkg::WD_RUN ##1 st_reg.wd == snw_pkg::WD_SAFE);
  c_safe_exit: cover property (safe_state ##1 !safe_state);
  c_refused: cover property (conn_refused);
  c_idle_close: cover property (|sess_close);
  c_qtmo: cover property (|qry_timeout);
endmodule

/* snw_pkg.sv */
// What this block does
// [RULE1] Eight switches pick baud, watchdog, framing, protocol
// [RULE2] Switches 1-3 binary code selects 1200..115200 baud
// [RULE3] Switches 5-7 binary code selects parity/data/stop
// [RULE4] Seven data bits force the RTU variant
// [RULE5] All switches off means 9600 N81, RTU; the decode gives 1200 N81 RTU for all-off, 9600 needs baud code 3
// [RULE6] Node identifier lies in range 01 to 99
// [RULE7] Tens rotary and units rotary form identifier
// [RULE8] Identifier 00 is broadcast, never own address
// [RULE9] Watchdog is off after reset unless enabled
// [RULE10] No query within timeout drives outputs safe
// [RULE11] Watchdog timeout is 16 bits, 100 ms units
// [RULE12] Idle TCP session closed after idle interval
// [RULE13] Idle interval zero never closes a session
// [RULE14] Up to eight TCP sessions open at once
// [RULE15] Per-query timeout in whole seconds bounds waiting
// [RULE16] Default watchdog timeout is fifty 100 ms units
// [RULE17] Valid query restarts watchdog; safe until write
package snw_pkg;
  // clock and time base
  localparam int CLK_HZ = 50_000_000;
  localparam int TICK_MS = 100;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int TICKS_PER_SEC = 1000 / TICK_MS;
  localparam int TICK_CW = 23;
  localparam int SUB_CW = 4;

  // widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int SLOTS = 8;
  localparam int SLOT_W = 3;
  localparam int CNT_W = 16;
  localparam int IRQ_W = 4;

  // register byte offsets
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_WD_TMO = 8'h04;
  localparam logic [7:0] REG_IDLE = 8'h08;
  localparam logic [7:0] REG_QTMO = 8'h0c;
  localparam logic [7:0] REG_IRQ_STAT = 8'h10;
  localparam logic [7:0] REG_IRQ_MASK = 8'h14;
  localparam logic [7:0] REG_SESS = 8'h18;

  // reset values
  localparam logic [15:0] WD_TMO_RST = 16'h0032;
  localparam logic [15:0] IDLE_RST = 16'h0000;
  localparam logic [15:0] QTMO_RST = 16'h0005;

  // switch fields
  localparam int DIP_BAUD_LSB = 0;
  localparam int DIP_WD = 3;
  localparam int DIP_FRM_LSB = 4;
  localparam int DIP_ASCII = 7;

  // framing codes
  localparam logic [2:0] FRM_E81 = 3'h1;
  localparam logic [2:0] FRM_O81 = 3'h2;
  localparam logic [2:0] FRM_N82 = 3'h3;
  localparam logic [2:0] FRM_N72 = 3'h4;
  localparam logic [2:0] FRM_E71 = 3'h5;
  localparam logic [2:0] FRM_O71 = 3'h6;

  // identifier limits
  localparam logic [3:0] BCD_MAX = 4'h9;
  localparam logic [6:0] ID_TENS_W = 7'h0a;
  localparam logic [7:0] ID_BCAST = 8'h00;

  // interrupt bits
  localparam int IRQ_WD = 0;
  localparam int IRQ_IDLE = 1;
  localparam int IRQ_QTMO = 2;
  localparam int IRQ_REFUSE = 3;

  localparam int BAUD_TAB [8] = '{1200, 2400, 4800, 9600, 19200, 38400, 57600, 115200};

  typedef enum logic [1:0] {SNW_NONE = 2'h0, SNW_EVEN = 2'h1, SNW_ODD = 2'h2} snw_parity_t;
  typedef enum logic [1:0] {WD_OFF = 2'h0, WD_RUN = 2'h1, WD_SAFE = 2'h3} snw_wd_t;

  typedef struct packed {
    logic [2:0] baud_code;
    logic [15:0] bit_div;
    snw_parity_t parity;
    logic seven_bits;
    logic two_stop;
    logic ascii;
  } snw_frame_t;

  typedef struct packed {
    logic [1:0] wd_state;
    logic safe;
    logic wd_en;
    logic ascii;
    logic two_stop;
    logic seven_bits;
    logic [1:0] parity;
    logic [2:0] baud_code;
    logic id_ok;
    logic [6:0] unit_id;
  } snw_status_t;

  typedef struct packed {
    logic [3:0] count;
    logic [7:0] qpend;
    logic [7:0] open;
  } snw_sess_t;

  typedef struct packed {
    logic [TICK_CW-1:0] cnt;
    logic [SUB_CW-1:0] sub;
    logic tick;
    logic sec;
  } snw_tick_state_t;

  // clock cycles per serial bit
  function automatic logic [15:0] baud_div(input logic [2:0] code);
    return 16'(CLK_HZ / BAUD_TAB[code]);
  endfunction

  function automatic snw_frame_t decode_frame(input logic [7:0] dip);
    snw_frame_t f;
    logic [2:0] fc;
    fc = dip[DIP_FRM_LSB +: 3];
    f.baud_code = dip[DIP_BAUD_LSB +: 3];
    f.bit_div = baud_div(f.baud_code);
    f.parity = SNW_NONE;
    f.seven_bits = 1'b0;
    f.two_stop = 1'b0;
    unique case (fc)
      FRM_E81: f.parity = SNW_EVEN;
      FRM_O81: f.parity = SNW_ODD;
      FRM_N82: f.two_stop = 1'b1;
      FRM_N72: begin
        f.seven_bits = 1'b1;
        f.two_stop = 1'b1;
      end
      FRM_E71: begin
        f.parity = SNW_EVEN;
        f.seven_bits = 1'b1;
      end
      FRM_O71: begin
        f.parity = SNW_ODD;
        f.seven_bits = 1'b1;
      end
      default: f.parity = SNW_NONE;
    endcase
    // ascii framing cannot carry seven-bit characters
    f.ascii = dip[DIP_ASCII] & ~f.seven_bits;
    return f;
  endfunction

  function automatic logic [6:0] bcd_id(input logic [3:0] t, input logic [3:0] u);
    return 7'({3'h0, t} * ID_TENS_W + {3'h0, u});
  endfunction

  function automatic logic [SLOT_W-1:0] first_free(input logic [SLOTS-1:0] open);
    logic [SLOT_W-1:0] r;
    r = '0;
    for (int i = SLOTS - 1; i >= 0; i--) begin
      if (!open[i]) begin
        r = SLOT_W'(i);
      end
    end
    return r;
  endfunction
endpackage

/* snw_tick_gen.sv */
`timescale 1ns/1ps
module snw_tick_gen #(
  parameter int TICK_CYCLES = snw_pkg::TICK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  output logic tick_100ms,
  output logic tick_sec
);
  snw_pkg::snw_tick_state_t st_reg;
  snw_pkg::snw_tick_state_t st_next;

  // one-cycle enables; the second tick is derived from the first so both stay aligned
  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    st_next.sec = 1'b0;
    if (st_reg.cnt == snw_pkg::TICK_CW'(TICK_CYCLES - 1)) begin
      st_next.cnt = '0;
      st_next.tick = 1'b1;
      if (st_reg.sub == snw_pkg::SUB_CW'(snw_pkg::TICKS_PER_SEC - 1)) begin
        st_next.sub = '0;
        st_next.sec = 1'b1;
      end else begin
        st_next.sub = st_reg.sub + 4'h1;
      end
    end else begin
      st_next.cnt = st_reg.cnt + 23'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick_100ms = st_reg.tick;
  assign tick_sec = st_reg.sec;

  a_sec_on_tick: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st_reg.sec |-> st_reg.tick) else $error("second tick without base tick"); // [RULE15]
endmodule

/* snw_host_model.sv */
`timescale 1ns/1ps
// host master: polls the node and drives the tcp session events
module snw_host_model (
  input wire logic ref_clk,
  input wire logic conn_grant,
  input wire logic conn_refused,
  input wire logic [2:0] conn_slot,
  output logic query_valid,
  output logic [7:0] query_unit,
  output logic out_write,
  output logic conn_req,
  output logic host_close,
  output logic [2:0] host_close_slot,
  output logic pkt_valid,
  output logic pkt_query,
  output logic [2:0] pkt_slot,
  output logic resp_done,
  output logic [2:0] resp_slot
);
  // everything quiet until the first request
  initial begin
    {query_valid, out_write, conn_req, host_close, pkt_valid, pkt_query, resp_done} = '0;
    {query_unit, host_close_slot, pkt_slot, resp_slot} = '0;
  end

  // aims at one node by its own id, or at 00 for everyone
  task automatic query(input logic [7:0] u);
    @(posedge ref_clk);
    query_valid <= 1'b1;
    query_unit <= u;
    @(posedge ref_clk);
    query_valid <= 1'b0;
    query_unit <= ~u; // address lines show junk once released
  endtask

  // new output values leave the safe state
  task automatic wr_out();
    @(posedge ref_clk);
    out_write <= 1'b1;
    @(posedge ref_clk);
    out_write <= 1'b0;
  endtask

  // open a session; the answer stands one cycle only
  task automatic conn(output logic g, output logic r, output logic [2:0] s);
    @(posedge ref_clk);
    conn_req <= 1'b1;
    @(posedge ref_clk);
    conn_req <= 1'b0;
    #1;
    g = conn_grant;
    r = conn_refused;
    s = conn_slot;
  endtask

  // k picks close, packet or response as {close, pkt, resp}
  task automatic slot_ev(input logic [2:0] k, input logic [2:0] s, input logic q);
    @(posedge ref_clk);
    {host_close, pkt_valid, resp_done} <= k;
    {host_close_slot, pkt_slot, resp_slot} <= {3{s}};
    pkt_query <= q;
    @(posedge ref_clk);
    {host_close, pkt_valid, resp_done} <= 3'h0;
    {host_close_slot, pkt_slot, resp_slot} <= {3{~s}};
    pkt_query <= ~q;
  endtask
endmodule

/* tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic ref_clk, arst_n, reg_wr, reg_rd, g, r;
  logic [7:0] cfg_dip, reg_addr, query_unit, sess_open, sess_close, qry_timeout;
  logic [7:0] seen_close, seen_qto;
  logic [3:0] id_tens, id_units;
  logic [31:0] reg_wdata, reg_rdata;
  logic query_valid, out_write, conn_req, host_close, pkt_valid, pkt_query, resp_done;
  logic [2:0] host_close_slot, pkt_slot, resp_slot, conn_slot, s;
  logic [6:0] unit_id;
  logic unit_id_ok, safe_state, conn_grant, conn_refused, irq;
  logic [4:0] fb;
  snw_pkg::snw_frame_t frame;
  int num_errors = 0;
  int n_tests = 0;
  int rates [8] = '{1200, 2400, 4800, 9600, 19200, 38400, 57600, 115200};
  logic [31:0] ft = 32'h0a631840; // {parity, seven, two_stop} per framing code
  logic [3:0] it [5] = '{4'h9, 4'h0, 4'h0, 4'ha, 4'h4};
  logic [3:0] iu [5] = '{4'h9, 4'h0, 4'h1, 4'h3, 4'h2};
  logic iok [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};

  // short tick so a second lasts 200 clocks
  snw_node_cfg #(.TICK_CYCLES(20)) uut (.ref_clk, .arst_n, .cfg_dip, .id_tens, .id_units,
    .query_valid, .query_unit, .out_write, .conn_req, .host_close, .host_close_slot,
    .pkt_valid, .pkt_query, .pkt_slot, .resp_done, .resp_slot, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .frame, .unit_id, .unit_id_ok, .safe_state, .conn_grant,
    .conn_refused, .conn_slot, .sess_open, .sess_close, .qry_timeout, .irq);
  snw_host_model host (.ref_clk, .conn_grant, .conn_refused, .conn_slot, .query_valid,
    .query_unit, .out_write, .conn_req, .host_close, .host_close_slot, .pkt_valid,
    .pkt_query, .pkt_slot, .resp_done, .resp_slot);

  assign fb = {frame.parity, frame.seven_bits, frame.two_stop, frame.ascii};

  // 50 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // one-cycle pulses are folded into sticky copies so no edge is missed
  always @(posedge ref_clk) begin
    seen_close <= seen_close | sess_close;
    seen_qto <= seen_qto | qry_timeout;
  end

  task automatic results();
    if (num_errors == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask

  // waits land 1 ns past the edge so outputs have settled
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e, "register read");
  endtask

  // switches pass two sync flops and a decode stage before showing
  task automatic setsw(input logic [7:0] d, input logic [3:0] t, input logic [3:0] u);
    @(posedge ref_clk);
    cfg_dip <= d;
    id_tens <= t;
    id_units <= u;
    cyc(6);
  endtask

  // hang guard, well above the roughly 1500 cycles the tests need
  initial begin
    cyc(6000);
    num_errors++;
    results();
  end

  initial begin
    // reset falls after time zero so every reset process is already waiting for the edge
    arst_n = 1'b1;
    cfg_dip = 8'h03;
    {id_tens, id_units} = 8'h42;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {seen_close, seen_qto} = '0;
    #1;
    arst_n = 1'b0;
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    cyc(6);
    // reset state with factory switches
    chk(frame, {3'h3, 16'h1458, 5'h00}, "factory framing");
    rchk(snw_pkg::REG_STATUS, 32'h000003aa);
    rchk(snw_pkg::REG_WD_TMO, 32'h00000032);
    rchk(snw_pkg::REG_IDLE, 32'h00000000);
    rchk(8'h1c, 32'h00000000); // unmapped place reads zero
    // every baud and framing code; ascii asked for throughout the framing sweep
    for (int b = 0; b < 8; b++) begin
      setsw(8'(b), 4'h4, 4'h2);
      chk(frame.bit_div, 32'(snw_pkg::CLK_HZ / rates[b]), "bit time");
    end
    for (int f = 0; f < 8; f++) begin
      setsw({1'b1, 3'(f), 4'h3}, 4'h4, 4'h2);
      chk(fb, {ft[f*4 +: 4], ~ft[f*4+1]}, "framing");
    end
    // rotary settings, valid and invalid, ending on 42
    for (int i = 0; i < 5; i++) begin
      setsw(8'h03, it[i], iu[i]);
      chk(unit_id_ok, iok[i], "id valid");
      if (iok[i]) begin
        chk(unit_id, int'(it[i]) * 10 + int'(iu[i]), "unit id");
      end
    end
    // watchdog: width, polling, trip, release
    wr(snw_pkg::REG_WD_TMO, 32'h0001ffff);
    rchk(snw_pkg::REG_WD_TMO, 32'h0000ffff);
    wr(snw_pkg::REG_WD_TMO, 32'h00000003);
    wr(snw_pkg::REG_IRQ_MASK, 32'h00000001);
    setsw(8'h0b, 4'h4, 4'h2);
    for (int i = 0; i < 4; i++) begin
      cyc(30);
      host.query(i[0] ? 8'h00 : 8'h2a);
    end
    cyc(35);
    chk(safe_state, 1'b0, "tripped early");
    host.query(8'h62);
    cyc(33);
    chk(safe_state, 1'b1, "no trip");
    chk(irq, 1'b1, "watchdog interrupt");
    rchk(snw_pkg::REG_STATUS, 32'h000f03aa);
    host.query(8'h2a);
    cyc(2);
    chk(safe_state, 1'b1, "query released safe");
    host.wr_out();
    cyc(2);
    chk(safe_state, 1'b0, "write kept safe");
    setsw(8'h03, 4'h4, 4'h2);
    wr(snw_pkg::REG_IRQ_STAT, 32'h00000001);
    rchk(snw_pkg::REG_IRQ_STAT, 32'h00000000);
    cyc(100);
    chk({safe_state, irq}, 2'b00, "disabled watchdog");
    // eight sessions, then a refusal
    wr(snw_pkg::REG_QTMO, 32'h00000002);
    for (int i = 0; i < 9; i++) begin
      host.conn(g, r, s);
      chk({g, r, s}, (i < 8) ? {2'b10, 3'(i)} : {2'b01, 3'h7}, "grant");
    end
    host.slot_ev(3'h2, 3'h2, 1'b1);
    host.slot_ev(3'h2, 3'h5, 1'b1);
    rchk(snw_pkg::REG_SESS, 32'h000824ff);
    host.slot_ev(3'h1, 3'h2, 1'b0);
    cyc(430);
    chk(seen_qto, 8'h20, "query timeout");
    chk(sess_open, 8'hff, "idle zero closed");
    host.slot_ev(3'h4, 3'h3, 1'b0);
    cyc(1);
    chk(sess_open, 8'hf7, "host close");
    host.conn(g, r, s);
    chk({g, r, s}, 5'h13, "lowest free slot");
    // slot 0 kept busy, the rest go idle
    for (int i = 0; i < 8; i++) begin
      host.slot_ev(3'h2, 3'(i), 1'b0);
    end
    wr(snw_pkg::REG_IDLE, 32'h00000002);
    for (int i = 0; i < 6; i++) begin
      cyc(90);
      host.slot_ev(3'h2, 3'h0, 1'b0);
    end
    chk({seen_close, sess_open}, 16'hfe01, "idle close");
    // sticky status, mask and write-one-to-clear
    rchk(snw_pkg::REG_IRQ_STAT, 32'h0000000e);
    chk(irq, 1'b0, "masked interrupt");
    wr(snw_pkg::REG_IRQ_MASK, 32'h00000004);
    cyc(1);
    chk(irq, 1'b1, "unmasked interrupt");
    wr(snw_pkg::REG_IRQ_STAT, 32'h00000002);
    rchk(snw_pkg::REG_IRQ_STAT, 32'h0000000c);
    results();
  end
endmodule
